/* hdl/phase_adjust_pkg.sv */
/*
 Package for the output phase adjust control block.
 Holds register offsets, field positions, reset values and step constants.
 Assumes a 32-bit AHB-Lite bus with word-aligned registers.
*/
package phase_adjust_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] TARGET_OFFSET = 8'h08;
    localparam logic [7:0] PHASE_OFFSET  = 8'h0C;
    localparam logic [7:0] RATE_OFFSET   = 8'h10;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int CTRL_FIXED_BIT    = 0;
    localparam int CTRL_AUTO_BIT     = 1;
    localparam int CTRL_HOLD_BIT     = 2;
    localparam int CTRL_CODE_LSB     = 4;
    localparam int CTRL_BW_LSB       = 6;
    localparam int CTRL_MAN_LSB      = 8;
    localparam logic [9:0] CTRL_RESET = 10'h002;

    // ==========================================================
    // Status register fields
    // ==========================================================
    localparam int STAT_SLEWING_BIT  = 0;
    localparam int STAT_FIXED_BIT    = 1;
    localparam int STAT_HITLESS_BIT  = 2;
    localparam int STAT_INVALID_BIT  = 3;
    localparam int STAT_IGNORED_BIT  = 4;

    // ==========================================================
    // Step size: two periods of the 32x output clock
    // ==========================================================
    localparam int OUT_MULT          = 32;
    localparam int PERIODS_PER_STEP  = 2;
    localparam logic [15:0] STEP_UNITS = 16'h0002;

    // Slew intervals per bandwidth code, in clock cycles between units
    localparam logic [15:0] SLEW_BW0 = 16'h0001;
    localparam logic [15:0] SLEW_BW1 = 16'h0004;
    localparam logic [15:0] SLEW_BW2 = 16'h0010;
    localparam logic [15:0] SLEW_BW3 = 16'h0040;

    // Code-rate scaling codes
    localparam logic [1:0] CODE_NONE    = 2'h0;
    localparam logic [1:0] CODE_FORWARD = 2'h1;
    localparam logic [1:0] CODE_REVERSE = 2'h2;

endpackage : phase_adjust_pkg

/* hdl/phase_slew.sv */
/*
 Phase slewing engine: moves the applied phase toward the target phase
 by one unit per slew interval.
 Assumes target changes are taken synchronously to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_slew
    import phase_adjust_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] target_i,
    input  wire logic [15:0]  interval_i,
    output logic      [W-1:0] phase_o,
    output logic              slewing_o
);

    logic [15:0] tick_r;

    // ==========================================================
    // Interval counter
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_r <= 16'h0000;
        end else if (ce_i) begin
            if (phase_o == target_i || tick_r + 16'h0001 >= interval_i) begin
                tick_r <= 16'h0000;
            end else begin
                tick_r <= tick_r + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Phase step, signed compare handles wrap
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_o   <= '0;
            slewing_o <= 1'b0;
        end else if (ce_i) begin
            slewing_o <= (phase_o != target_i);
            if (phase_o != target_i && tick_r + 16'h0001 >= interval_i) begin
                if ($signed(target_i - phase_o) > 0) begin
                    phase_o <= phase_o + W'(1);
                end else begin
                    phase_o <= phase_o - W'(1);
                end
            end
        end
    end

endmodule : phase_slew
`default_nettype wire

/* hdl/phase_adjust_ctrl.sv */
/*
 Output phase adjust control: pulse pins step a target phase, a slewing
 engine moves the applied phase there at a bandwidth-set rate.
 Assumes pins are synchronous to clk_i and an AHB-Lite master on the bus.
*/
// Notes on behaviour
// - Increase pulse adds two periods of the 32x output clock.
// - Decrease pulse removes two periods of the 32x output clock.
// - Step period comes from the 32x clock, scaled by code-rate setting.
// - Phase slews to the target at a bandwidth-selected rate.
// - Increase pulses are ignored during holdover.
// - Fixed-phase enable, active high, keeps input-output phase constant.
// - Fixed-phase plus manual selection disables hitless holdover recovery.
// - Fixed phase holds only while manual input choice stays unchanged.
// - Automatic selection makes fixed-phase enable ignored.
`timescale 1ns/1ps
`default_nettype none
module phase_adjust_ctrl
    import phase_adjust_pkg::*;
#(
    parameter int PHASE_W = 16
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    input  wire logic               delay_increase_pulse_i,
    input  wire logic               delay_decrease_pulse_i,
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic      [31:0]        hrdata_o,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    output logic      [PHASE_W-1:0] phase_o,
    output logic                    slewing_o,
    output logic                    hitless_enable_o,
    output logic                    fixed_phase_active_o
);

    logic [9:0]         ctrl_r;
    logic [PHASE_W-1:0] target_r;
    logic               inc_d_r;
    logic               dec_d_r;
    logic               invalid_r;
    logic               ignored_r;
    logic [1:0]         man_ref_r;
    logic               fixed_lost_r;
    logic               fixed_d_r;
    logic               wr_pend_r;
    logic [7:0]         wr_addr_r;
    logic [PHASE_W-1:0] slew_phase;
    logic               slew_busy;
    logic [15:0]        interval;
    logic               fixed_eff;
    logic               holdover;
    logic [1:0]         code_sel;
    logic [1:0]         bw_sel;
    logic [1:0]         man_sel;
    logic               inc_rise;
    logic               dec_rise;
    logic               both_high;
    logic               rd_req;
    logic               wr_req;
    logic [31:0]        rd_data;
    logic [15:0]        step_units;

    assign holdover = ctrl_r[CTRL_HOLD_BIT];
    assign code_sel = ctrl_r[CTRL_CODE_LSB +: 2];
    assign bw_sel   = ctrl_r[CTRL_BW_LSB +: 2];
    assign man_sel  = ctrl_r[CTRL_MAN_LSB +: 2];
    assign fixed_eff = ctrl_r[CTRL_FIXED_BIT] & ~ctrl_r[CTRL_AUTO_BIT];

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // ==========================================================
    assign rd_req = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    assign wr_req = hsel_i & hready_i & htrans_i[1] & hwrite_i;

    // Writes land one edge later, when hwdata stands on the bus
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (ce_i) begin
            wr_pend_r <= wr_req;
            if (wr_req) begin
                wr_addr_r <= haddr_i[7:0];
            end
        end
    end

    // ==========================================================
    // Register read mux
    // ==========================================================
    always_comb begin
        rd_data = 32'h0000_0000;
        case (haddr_i[7:0])
            CTRL_OFFSET: begin
                rd_data[9:0] = ctrl_r;
            end
            STATUS_OFFSET: begin
                rd_data[STAT_SLEWING_BIT] = slew_busy;
                rd_data[STAT_FIXED_BIT]   = fixed_eff & ~fixed_lost_r;
                rd_data[STAT_HITLESS_BIT] = hitless_enable_o;
                rd_data[STAT_INVALID_BIT] = invalid_r;
                rd_data[STAT_IGNORED_BIT] = ignored_r;
            end
            TARGET_OFFSET: begin
                rd_data[PHASE_W-1:0] = target_r;
            end
            PHASE_OFFSET: begin
                rd_data[PHASE_W-1:0] = slew_phase;
            end
            RATE_OFFSET: begin
                rd_data[15:0] = interval;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else if (ce_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            // Launched at the address edge, stands for the whole data phase
            if (rd_req) begin
                hrdata_o <= rd_data;
            end
        end
    end

    // ==========================================================
    // Control register
    // ==========================================================
    // Mode bits are software-set; there are no separate mode pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (ce_i) begin
            if (wr_pend_r && wr_addr_r == CTRL_OFFSET) begin
                ctrl_r <= hwdata_i[9:0];
            end
        end
    end

    // ==========================================================
    // Pulse pins: rising-edge detect
    // ==========================================================
    // The board keeps the other pin low; both high is refused.
    assign both_high = delay_increase_pulse_i & delay_decrease_pulse_i;
    assign inc_rise  = delay_increase_pulse_i & ~inc_d_r & ~both_high;
    assign dec_rise  = delay_decrease_pulse_i & ~dec_d_r & ~both_high;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            inc_d_r <= 1'b0;
            dec_d_r <= 1'b0;
        end else if (ce_i) begin
            inc_d_r <= delay_increase_pulse_i;
            dec_d_r <= delay_decrease_pulse_i;
        end
    end

    // Sticky flags; a new event wins over the clear by write.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            invalid_r <= 1'b0;
            ignored_r <= 1'b0;
        end else if (ce_i) begin
            if (both_high && !(inc_d_r && dec_d_r)) begin
                invalid_r <= 1'b1;
            end else if (wr_pend_r && wr_addr_r == STATUS_OFFSET &&
                         hwdata_i[STAT_INVALID_BIT]) begin
                invalid_r <= 1'b0;
            end
            if (inc_rise && holdover) begin
                ignored_r <= 1'b1;
            end else if (wr_pend_r && wr_addr_r == STATUS_OFFSET &&
                         hwdata_i[STAT_IGNORED_BIT]) begin
                ignored_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Step size in units of the scaled 32x output period
    // ==========================================================
    // Units are the scaled output period, so the code-rate setting only
    // changes the time of a unit, never the count of units per step.
    always_comb begin
        case (code_sel)
            CODE_FORWARD: step_units = STEP_UNITS;
            CODE_REVERSE: step_units = STEP_UNITS;
            default:      step_units = STEP_UNITS;
        endcase
    end

    // ==========================================================
    // Target phase
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_r <= '0;
        end else if (ce_i) begin
            // Decrease stays live in holdover; only increase is refused
            if (inc_rise && !holdover) begin
                target_r <= target_r + step_units[PHASE_W-1:0];
            end else if (dec_rise) begin
                target_r <= target_r - step_units[PHASE_W-1:0];
            end
        end
    end

    // ==========================================================
    // Fixed-phase tracking and hitless recovery
    // ==========================================================
    // Choice in force when fixed phase turns on is the reference, even if
    // the same write changed it; a lagging copy would flag a false loss.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fixed_d_r <= 1'b0;
        end else if (ce_i) begin
            fixed_d_r <= fixed_eff;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            man_ref_r    <= 2'h0;
            fixed_lost_r <= 1'b0;
        end else if (ce_i) begin
            if (!fixed_eff) begin
                man_ref_r    <= man_sel;
                fixed_lost_r <= 1'b0;
            end else if (!fixed_d_r) begin
                man_ref_r    <= man_sel;
            end else if (man_sel != man_ref_r) begin
                fixed_lost_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hitless_enable_o     <= 1'b1;
            fixed_phase_active_o <= 1'b0;
        end else if (ce_i) begin
            // Hitless recovery would move the phase, so fixed mode drops it
            hitless_enable_o     <= ~fixed_eff;
            fixed_phase_active_o <= fixed_eff & ~fixed_lost_r;
        end
    end

    // ==========================================================
    // Slew rate from bandwidth select
    // ==========================================================
    always_comb begin
        case (bw_sel)
            2'h0:    interval = SLEW_BW0;
            2'h1:    interval = SLEW_BW1;
            2'h2:    interval = SLEW_BW2;
            default: interval = SLEW_BW3;
        endcase
    end

    // The engine owns the applied phase; phase_o is a registered copy
    phase_slew #(
        .W (PHASE_W)
    ) u_slew (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .target_i   (target_r),
        .interval_i (interval),
        .phase_o    (slew_phase),
        .slewing_o  (slew_busy)
    );

    // ==========================================================
    // Applied phase outputs
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_o   <= '0;
            slewing_o <= 1'b0;
        end else if (ce_i) begin
            phase_o   <= slew_phase;
            slewing_o <= slew_busy;
        end
    end

endmodule : phase_adjust_ctrl
`default_nettype wire

/* test/phase_adjust_properties.sv */
/* Checker for phase_adjust_ctrl, bound to its ports.
   Assumes one clock, asynchronous active-high reset, zero-wait bus. */
`timescale 1ns/1ps
`default_nettype none
module phase_adjust_properties
    import phase_adjust_pkg::*;
#(
    parameter int PHASE_W = 16
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               ce_i,
    input wire logic               delay_increase_pulse_i,
    input wire logic               delay_decrease_pulse_i,
    input wire logic               hsel_i,
    input wire logic [31:0]        haddr_i,
    input wire logic [1:0]         htrans_i,
    input wire logic               hwrite_i,
    input wire logic [2:0]         hsize_i,
    input wire logic [31:0]        hwdata_i,
    input wire logic               hready_i,
    input wire logic [31:0]        hrdata_o,
    input wire logic               hreadyout_o,
    input wire logic               hresp_o,
    input wire logic [PHASE_W-1:0] phase_o,
    input wire logic               slewing_o,
    input wire logic               hitless_enable_o,
    input wire logic               fixed_phase_active_o
);
    // ==========================================
    // Shadow of the control word and step base
    // ==========================================
    logic [9:0]         ctrl_r;
    logic               wr_r;
    logic [PHASE_W-1:0] base_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
            wr_r   <= 1'b0;
            base_r <= '0;
        end else begin
            wr_r <= hsel_i && hready_i && htrans_i[1] && hwrite_i && ce_i
                    && haddr_i[7:0] == CTRL_OFFSET;
            if (wr_r && ce_i) begin
                ctrl_r <= hwdata_i[9:0];
            end
            // Step base taken only from an idle phase
            if (ce_i && !slewing_o && ($rose(delay_increase_pulse_i)
                || $rose(delay_decrease_pulse_i))) begin
                base_r <= phase_o;
            end
        end
    end
    wire fix_eff = ctrl_r[0] && !ctrl_r[1];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ==========================================
    // Sequences
    // ==========================================
    sequence inc_req(h);
        ce_i && $rose(delay_increase_pulse_i) && !delay_decrease_pulse_i
        && !slewing_o && ctrl_r[2] == h;
    endsequence
    sequence dec_req;
        ce_i && $rose(delay_decrease_pulse_i) && !delay_increase_pulse_i && !slewing_o;
    endsequence
    sequence quiet_s;
        !slewing_o [*3];
    endsequence
    sequence ctrl_steady;
        ctrl_r == $past(ctrl_r) && ctrl_r == $past(ctrl_r, 2);
    endsequence

    // ==========================================
    // Properties
    // ==========================================
    phase_unit_a: assert property (
        (phase_o - $past(phase_o)) inside {16'h0000, 16'h0001, 16'hFFFF})
        else $error("phase jumped by more than one unit");
    slew_flag_a: assert property (
        $changed(phase_o) |-> slewing_o)
        else $error("phase moved without slewing flag");
    inc_step_a: assert property (
        inc_req(1'b0) |-> ##[2:300] phase_o == base_r + STEP_UNITS)
        else $error("increase step not reached");
    dec_step_a: assert property (
        dec_req |-> ##[2:300] phase_o == base_r - STEP_UNITS)
        else $error("decrease step not reached");
    hold_ignore_a: assert property (
        inc_req(1'b1) |=> quiet_s)
        else $error("increase acted on in holdover");
    both_high_a: assert property (
        ce_i && $rose(delay_increase_pulse_i) && $rose(delay_decrease_pulse_i)
        && !slewing_o |=> quiet_s)
        else $error("invalid request acted on");
    hitless_mode_a: assert property (
        ctrl_steady |-> hitless_enable_o == !fix_eff)
        else $error("hitless enable wrong for mode");
    fixed_off_a: assert property (
        ctrl_steady and !fix_eff |-> !fixed_phase_active_o)
        else $error("fixed phase active while not enabled");
    choice_change_a: assert property (
        fix_eff && ctrl_r[9:8] != $past(ctrl_r[9:8]) && $past(fix_eff)
        |-> ##[1:3] !fixed_phase_active_o)
        else $error("fixed phase kept after choice change");
endmodule : phase_adjust_properties

bind phase_adjust_ctrl phase_adjust_properties #(.PHASE_W(PHASE_W)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .delay_increase_pulse_i(delay_increase_pulse_i),
    .delay_decrease_pulse_i(delay_decrease_pulse_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .phase_o(phase_o),
    .slewing_o(slewing_o), .hitless_enable_o(hitless_enable_o),
    .fixed_phase_active_o(fixed_phase_active_o));
`default_nettype wire

/* test/board_pulse_model.sv */
/* Board logic that drives the two phase adjust pins.
   Assumes the bench starts one pulse at a time with go_i. */
`timescale 1ns/1ps
`default_nettype none
module board_pulse_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [1:0] kind_i,
    input  wire logic [2:0] hi_i,
    output logic            inc_o,
    output logic            dec_o,
    output logic            done_o
);
    // ==========================================
    // Pulse shaper: hi_i+1 cycles high for hi_i up to 4, at least three low
    // ==========================================
    logic [2:0] cnt_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= 3'h0;
            inc_o  <= 1'b0;
            dec_o  <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= cnt_r == 3'h1;
            if (go_i && cnt_r == 3'h0) begin
                cnt_r <= hi_i + 3'h3;
                inc_o <= kind_i[0];
                dec_o <= kind_i[1];
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
                if (cnt_r == 3'h3) begin
                    inc_o <= 1'b0;
                    dec_o <= 1'b0;
                end
            end
        end
    end
    // Input choice is never touched here, only by the bench
endmodule : board_pulse_model
`default_nettype wire

/* test/testbench.sv */
/* Self-checking bench for phase_adjust_ctrl.
   Assumes zero-wait slave, fixed seed, board model on the pins. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import phase_adjust_pkg::*;
    logic        clk_i = 0, rst_i = 1, ce_i = 1, hsel_i = 0, hwrite_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, rd, r, hrdata_o, seed = 78;
    logic [1:0]  htrans_i = 0, kind = 0, kd;
    logic [2:0]  hi = 1;
    logic        go = 0, inc, dec, done, hreadyout_o, hresp_o, slewing_o, hit, fxa;
    logic [15:0] phase_o, exp_ph, iv;
    int          err_count = 0, check_count = 0, sl, i;
    always #50 clk_i = ~clk_i;

    phase_adjust_ctrl i_phase_adjust_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .delay_increase_pulse_i(inc), .delay_decrease_pulse_i(dec), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .phase_o(phase_o),
        .slewing_o(slewing_o), .hitless_enable_o(hit), .fixed_phase_active_o(fxa));
    board_pulse_model i_board_pulse_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .kind_i(kind), .hi_i(hi), .inc_o(inc), .dec_o(dec), .done_o(done));

    // ==========================================
    // Helpers
    // ==========================================
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function logic [31:0] ctrl(input int f, a, h, c, b, m);
        return {22'h0, 2'(m), 2'(b), 2'(c), 1'b0, 1'(h), 1'(a), 1'(f)};
    endfunction : ctrl
    function logic [15:0] iv_of(input int b);
        return b == 0 ? SLEW_BW0 : b == 1 ? SLEW_BW1 : b == 2 ? SLEW_BW2 : SLEW_BW3;
    endfunction : iv_of
    task conclude;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task check(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask : check
    task wait_rdy;
        int n;
        n = 0;
        do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            $display("Error at %0t: bus timeout", $time);
            conclude();
        end
    endtask : wait_rdy
    // Address phase held until hready, then data phase until hready
    task bus(input logic [7:0] a, input int w, input logic [31:0] wd);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h0, a};
        hwrite_i <= 1'(w);
        wait_rdy();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_rdy();
        rd = hrdata_o;
        check({31'h0, hresp_o}, 32'h0);
    endtask : bus
    task pulse(input logic [1:0] k, input logic [2:0] h);
        int n;
        logic dn;
        go <= 1'b1;
        kind <= k;
        hi <= h;
        @(posedge clk_i);
        go <= 1'b0;
        n = 0;
        sl = 0;
        dn = 1'b0;
        do begin
            @(posedge clk_i);
            n++;
            if (slewing_o === 1'b1) sl++;
            if (done === 1'b1) dn = 1'b1;
        end while ((dn !== 1'b1 || slewing_o !== 1'b0) && n < 400);
        repeat (2) @(posedge clk_i);
        if (n >= 400) begin
            err_count++;
            $display("Error at %0t: pulse timeout", $time);
            conclude();
        end
    endtask : pulse

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({phase_o, 13'h0, slewing_o, hit, fxa}, 32'h0000_0002);
        bus(CTRL_OFFSET, 0, 0);
        check(rd, {22'h0, CTRL_RESET});
        bus(8'h20, 1, 32'hFFFF_FFFF);
        bus(8'h20, 0, 0);
        check(rd, 32'h0);
        exp_ph = 16'h0000;
        for (i = 0; i < 10; i++) begin
            r = rnd();
            bus(CTRL_OFFSET, 1, ctrl(0, 1, 0, i % 3, i < 4 ? i : r[1:0], r[9:8]));
            iv = iv_of(i < 4 ? i : r[1:0]);
            bus(RATE_OFFSET, 0, 0);
            check(rd, {16'h0, iv});
            kd = (i == 0 || r[4]) ? 2'h2 : 2'h1;
            pulse(kd, {1'b0, r[6:5]} + 3'h1);
            exp_ph = kd == 2'h1 ? exp_ph + STEP_UNITS : exp_ph - STEP_UNITS;
            check({16'h0, phase_o}, {16'h0, exp_ph});
            check({31'h0, sl >= iv && sl <= 2 * iv + 3}, 32'h1);
        end
        bus(CTRL_OFFSET, 1, ctrl(0, 1, 1, 0, 0, 0));
        pulse(2'h1, 3'h1);
        check({16'h0, phase_o}, {16'h0, exp_ph});
        bus(STATUS_OFFSET, 0, 0);
        check({31'h0, rd[STAT_IGNORED_BIT]}, 32'h1);
        bus(STATUS_OFFSET, 1, 32'h0000_0018);
        pulse(2'h3, 3'h2);
        check({16'h0, phase_o}, {16'h0, exp_ph});
        bus(STATUS_OFFSET, 0, 0);
        check({30'h0, rd[4:3]}, 32'h1);
        pulse(2'h2, 3'h1);
        exp_ph = exp_ph - STEP_UNITS;
        check({16'h0, phase_o}, {16'h0, exp_ph});
        ce_i <= 1'b0;
        pulse(2'h2, 3'h1);
        ce_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check({16'h0, phase_o}, {16'h0, exp_ph});
        bus(CTRL_OFFSET, 1, ctrl(1, 0, 0, 0, 0, 1));
        repeat (3) @(posedge clk_i);
        check({30'h0, hit, fxa}, 32'h1);
        bus(CTRL_OFFSET, 1, ctrl(1, 0, 0, 0, 0, 2));
        repeat (3) @(posedge clk_i);
        check({30'h0, hit, fxa}, 32'h0);
        bus(CTRL_OFFSET, 1, ctrl(1, 1, 0, 0, 0, 2));
        repeat (3) @(posedge clk_i);
        check({30'h0, hit, fxa}, 32'h2);
        conclude();
    end
endmodule : testbench
`default_nettype wire
